// ==== logic/spfc_pkg.sv ====
package spfc_pkg;

    // =========================================================
    // Clock and timing
    localparam real CLK_PERIOD_NS = 25.0;
    localparam real VERIFY_BLK_MS = 6.8;
    localparam real VERIFY_BYTE_US = 27.0;
    localparam real ERASE_MS = 8.5;
    localparam real BLANK_US = 480.0;
    localparam real WRITE_US = 150.0;
    localparam int VERIFY_BLK_CYC = int'(VERIFY_BLK_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int VERIFY_BYTE_CYC = int'(VERIFY_BYTE_US * 1.0e3 / CLK_PERIOD_NS);
    localparam int ERASE_CYC = int'(ERASE_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int BLANK_CYC = int'(BLANK_US * 1.0e3 / CLK_PERIOD_NS);
    localparam int WRITE_CYC = int'(WRITE_US * 1.0e3 / CLK_PERIOD_NS);
    localparam int TMR_W = 24;

    // =========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PCMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_APH = 8'h10;
    localparam logic [7:0] OFS_APL = 8'h14;
    localparam logic [7:0] OFS_ACH = 8'h18;
    localparam logic [7:0] OFS_ACL = 8'h1c;
    localparam logic [7:0] OFS_WBUF = 8'h20;

    // =========================================================
    // Fields and values
    localparam int MODE_SPM_BIT = 0;
    localparam int MODE_PROT_LSB = 2;
    localparam int ST_PERR = 0;
    localparam int ST_VCERR = 1;
    localparam int ST_WEPR = 2;
    localparam logic [7:0] PCMD_KEY = 8'ha5;
    localparam logic [7:0] BLANK_VAL = 8'hff;
    localparam logic [11:0] PROT_ADDR = 12'h081;
    localparam logic [3:0] HI_RSVD_ZERO = 4'h0;

    typedef enum logic [7:0] {
        CMD_VERIFY = 8'h01,
        CMD_ERASE = 8'h03,
        CMD_BLANK = 8'h04,
        CMD_WRITE = 8'h05
    } spfc_cmd_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_KEY = 2'b01,
        SEQ_VAL = 2'b10,
        SEQ_INV = 2'b11
    } spfc_seq_e;

    typedef struct packed {
        logic [7:0] cmd;
        logic [11:0] addr;
        logic [11:0] cmp;
        logic [7:0] wdata;
    } spfc_op_s;

endpackage

// ==== logic/spfc_timer.sv ====
`timescale 1ns/1ps
module spfc_timer
    import spfc_pkg::*;
#(
    parameter int W = TMR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    logic [W-1:0] cnt_q;

    // =========================================================
    // Down counter, done in the last counted cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign done = (cnt_q == W'(1));
endmodule

// ==== logic/spfc_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// [R1] HALT in self programming mode starts command
// [R2] HALT released automatically when command finishes
// [R3] Mode entry only through protected write sequence
// [R4] No maskable interrupt service in self mode
// [R5] Verify: 6.8 ms block, 27 us byte
// [R6] Block erase completes 8.5 ms after HALT
// [R7] Erased bytes read back as FFH
// [R8] Blank check completes 480 us after HALT
// [R9] Byte write completes 150 us after HALT
// [R10] CPU stalled while command runs
// [R11] No RAM access while command runs
// [R12] Software waits 16 us before HALT
// [R13] Pins held as in HALT during mode
// [R14] External security ignored; protect byte only
// [R15] Protect settings read from flash 0081H
// [R16] Software clears high pointer bits 4-7
// [R17] Software restarts watchdog before command
// [R18] Written flash readable by CPU loads
// [R19] Mode bit 0 selects mode, reset clears
// [R20] Key A5H, value, inverse, value commits write
// [R21] Command and operands latched at HALT
module spfc_ctrl
    import spfc_pkg::*;
#(
    parameter int FLASH_AW = 8,
    parameter int BLK_W = 6,
    parameter int VERIFY_BLK_CYCLES = VERIFY_BLK_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int BLANK_CYCLES = BLANK_CYC,
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU side
    input wire logic halt_exec,
    output logic cpu_stall,
    output logic halt_release,
    output logic int_service_en,
    output logic pin_hold,
    output logic ram_access_en,
    input wire logic [FLASH_AW-1:0] cpu_rd_addr,
    output logic [7:0] cpu_rd_data
);
    localparam int FLASH_BYTES = 1 << FLASH_AW;
    localparam int BLK_BYTES = 1 << BLK_W;
    localparam int BN_W = FLASH_AW - BLK_W;

    logic [7:0] mem_q [FLASH_BYTES];
    logic spm_q, prot_ld_q, busy_q, err_q, rel_q;
    logic [4:0] prot_q;
    logic [2:0] stat_q;
    logic [7:0] cmd_q, aph_q, apl_q, ach_q, acl_q, wbuf_q, seqval_q;
    spfc_seq_e seq_q;
    spfc_op_s op_q, op_d;
    logic [31:0] rdata_q;
    logic wr_en, rd_setup, mapped, start, tmr_done, fin;
    logic err_d, vc_d, wp_d, blank_ok, wr_mode, wr_other;
    logic [TMR_W-1:0] len_d;
    logic [BN_W-1:0] blk_d;
    logic [11:0] span;

    // =========================================================
    // APB decode
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        case (paddr)
            OFS_MODE, OFS_PCMD, OFS_STAT, OFS_CMD, OFS_APH, OFS_APL,
            OFS_ACH, OFS_ACL, OFS_WBUF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;
    assign wr_mode = wr_en && (paddr == OFS_MODE);
    assign wr_other = wr_en && (paddr != OFS_MODE) && (paddr != OFS_PCMD);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (rd_setup) begin
            case (paddr)
                OFS_MODE: rdata_q <= {24'h0, 1'b0, prot_q, 1'b0, spm_q};
                OFS_STAT: rdata_q <= {29'h0, stat_q};
                OFS_CMD: rdata_q <= {24'h0, cmd_q};
                OFS_APH: rdata_q <= {24'h0, aph_q};
                OFS_APL: rdata_q <= {24'h0, apl_q};
                OFS_ACH: rdata_q <= {24'h0, ach_q};
                OFS_ACL: rdata_q <= {24'h0, acl_q};
                OFS_WBUF: rdata_q <= {24'h0, wbuf_q};
                default: rdata_q <= '0;
            endcase
        end
    end
    assign prdata = rdata_q;

    // =========================================================
    // Operand registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_q <= '0;
            aph_q <= '0;
            apl_q <= '0;
            ach_q <= '0;
            acl_q <= '0;
            wbuf_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CMD: cmd_q <= pwdata[7:0];
                OFS_APH: aph_q <= pwdata[7:0];
                OFS_APL: apl_q <= pwdata[7:0];
                OFS_ACH: ach_q <= pwdata[7:0];
                OFS_ACL: acl_q <= pwdata[7:0];
                OFS_WBUF: wbuf_q <= pwdata[7:0];
                default: cmd_q <= cmd_q;
            endcase
        end
    end

    // =========================================================
    // Protected write sequence and mode bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_q <= SEQ_IDLE;
            seqval_q <= '0;
            spm_q <= 1'b0; // R19
        end else if (wr_en && (paddr == OFS_PCMD)) begin
            seq_q <= (pwdata[7:0] == PCMD_KEY) ? SEQ_KEY : SEQ_IDLE; // R20
        end else if (wr_en) begin
            case (seq_q)
                SEQ_KEY: begin
                    seq_q <= wr_mode ? SEQ_VAL : SEQ_IDLE;
                    seqval_q <= pwdata[7:0];
                end
                SEQ_VAL: begin
                    seq_q <= (wr_mode && pwdata[7:0] == ~seqval_q) ? SEQ_INV : SEQ_IDLE;
                end
                SEQ_INV: begin
                    seq_q <= SEQ_IDLE;
                    if (wr_mode && pwdata[7:0] == seqval_q) begin
                        spm_q <= pwdata[MODE_SPM_BIT]; // R3 R20
                    end
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    // =========================================================
    // Protect byte capture after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prot_ld_q <= 1'b0;
            prot_q <= '0;
        end else if (!prot_ld_q) begin
            prot_ld_q <= 1'b1;
            prot_q <= mem_q[PROT_ADDR[FLASH_AW-1:0]][4:0]; // R15
        end
    end

    // =========================================================
    // Command evaluation at HALT
    assign start = halt_exec && spm_q && !busy_q; // R1
    always_comb begin
        op_d = '{cmd: cmd_q, addr: {aph_q[3:0], apl_q}, cmp: {ach_q[3:0], acl_q},
                 wdata: wbuf_q}; // R21
        blk_d = op_d.addr[FLASH_AW-1:BLK_W];
        span = op_d.cmp - op_d.addr;
        vc_d = (aph_q[7:4] != HI_RSVD_ZERO) || (ach_q[7:4] != HI_RSVD_ZERO) ||
               ((op_d.addr >> FLASH_AW) != 12'h0);
        wp_d = 1'b0;
        len_d = TMR_W'(1);
        case (op_d.cmd)
            CMD_VERIFY: begin
                vc_d = vc_d || (op_d.cmp < op_d.addr) ||
                       (op_d.cmp[11:BLK_W] != op_d.addr[11:BLK_W]);
                if (span == 12'(BLK_BYTES - 1)) begin
                    len_d = TMR_W'(VERIFY_BLK_CYCLES); // R5
                end else begin
                    len_d = TMR_W'((32'(span) + 32'd1) * 32'(VERIFY_BYTE_CYC)); // R5
                end
            end
            CMD_ERASE: begin
                wp_d = (32'(blk_d) >= 32'(prot_q)); // R14
                len_d = TMR_W'(ERASE_CYCLES); // R6
            end
            CMD_BLANK: len_d = TMR_W'(BLANK_CYCLES); // R8
            CMD_WRITE: begin
                wp_d = (32'(blk_d) >= 32'(prot_q)); // R14
                len_d = TMR_W'(WRITE_CYCLES); // R9
            end
            default: vc_d = 1'b1;
        endcase
        err_d = vc_d || wp_d;
        if (err_d) begin
            len_d = TMR_W'(1);
        end
    end

    spfc_timer #(
        .W(TMR_W)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .load(start),
        .load_val(len_d),
        .done(tmr_done)
    );

    assign fin = busy_q && tmr_done;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
            err_q <= 1'b0;
            op_q <= '0;
            rel_q <= 1'b0;
        end else begin
            rel_q <= fin; // R2
            if (start) begin
                busy_q <= 1'b1;
                err_q <= err_d;
                op_q <= op_d;
            end else if (fin) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign cpu_stall = busy_q; // R10
    assign halt_release = rel_q;
    assign ram_access_en = !busy_q; // R11
    assign int_service_en = !spm_q; // R4
    assign pin_hold = spm_q; // R13

    // =========================================================
    // Flash array
    always_comb begin
        blank_ok = 1'b1;
        for (int i = 0; i < BLK_BYTES; i++) begin
            if (mem_q[{op_q.addr[FLASH_AW-1:BLK_W], BLK_W'(i)}] != BLANK_VAL) begin
                blank_ok = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < FLASH_BYTES; i++) begin
                mem_q[i] <= BLANK_VAL;
            end
        end else if (fin && !err_q) begin
            if (op_q.cmd == CMD_ERASE) begin
                for (int i = 0; i < BLK_BYTES; i++) begin
                    mem_q[{op_q.addr[FLASH_AW-1:BLK_W], BLK_W'(i)}] <= BLANK_VAL; // R7
                end
            end else if (op_q.cmd == CMD_WRITE) begin
                mem_q[op_q.addr[FLASH_AW-1:0]] <=
                    mem_q[op_q.addr[FLASH_AW-1:0]] & op_q.wdata; // R9
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_rd_data <= '0;
        end else begin
            cpu_rd_data <= mem_q[cpu_rd_addr]; // R18
        end
    end

    // =========================================================
    // Status flags, set wins over a write of zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat_q <= '0;
        end else begin
            if (wr_en && paddr == OFS_STAT) begin
                stat_q <= stat_q & pwdata[2:0];
            end
            if ((wr_mode && seq_q == SEQ_IDLE) || (wr_en && paddr == OFS_PCMD &&
                (seq_q != SEQ_IDLE || pwdata[7:0] != PCMD_KEY)) ||
                (wr_other && seq_q != SEQ_IDLE) ||
                (wr_mode && seq_q == SEQ_VAL && pwdata[7:0] != ~seqval_q) ||
                (wr_mode && seq_q == SEQ_INV && pwdata[7:0] != seqval_q)) begin
                stat_q[ST_PERR] <= 1'b1; // R3
            end
            if (start && wp_d) begin
                stat_q[ST_WEPR] <= 1'b1; // R15
            end
            if ((start && vc_d) || (fin && !err_q &&
                ((op_q.cmd == CMD_BLANK && !blank_ok) || (op_q.cmd == CMD_WRITE &&
                (mem_q[op_q.addr[FLASH_AW-1:0]] & op_q.wdata) != op_q.wdata)))) begin
                stat_q[ST_VCERR] <= 1'b1;
            end
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    int unsigned busy_cnt;
    int unsigned exp_cnt;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_cnt <= 0;
            exp_cnt <= 0;
        end else if (start) begin
            busy_cnt <= 0;
            exp_cnt <= 32'(len_d);
        end else if (busy_q) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    sequence s_cmd_start;
        halt_exec && spm_q && !busy_q;
    endsequence
    sequence s_cmd_end;
        busy_q && tmr_done;
    endsequence

    chk_halt_starts: assert property (s_cmd_start |=> busy_q && cpu_stall) // R1
        else $error("HALT did not start command");
    chk_auto_release: assert property (s_cmd_end |=> !busy_q ##0 halt_release) // R2
        else $error("HALT not released after command");
    chk_cmd_duration: assert property ($fell(busy_q) |-> busy_cnt == exp_cnt) // R5 R6 R8 R9
        else $error("Command duration wrong");
    chk_direct_mode_blocked: assert property (wr_mode && seq_q == SEQ_IDLE
        |=> $stable(spm_q) && stat_q[ST_PERR]) // R3
        else $error("Unprotected mode write took effect");
    chk_seq_commit: assert property (wr_mode && seq_q == SEQ_INV && pwdata[7:0] == seqval_q
        |=> spm_q == $past(pwdata[0])) // R20
        else $error("Protected sequence did not commit");
    chk_no_int_service: assert property (spm_q |-> !int_service_en && pin_hold) // R4 R13
        else $error("Interrupt service or pins active in self mode");
    chk_stall_no_ram: assert property (busy_q |-> cpu_stall && !ram_access_en) // R10 R11
        else $error("CPU or RAM active during command");
    chk_erase_blank: assert property (s_cmd_end and (!err_q && op_q.cmd == CMD_ERASE)
        |=> mem_q[{op_q.addr[FLASH_AW-1:BLK_W], BLK_W'(0)}] == BLANK_VAL) // R7
        else $error("Erased byte not blank");
    chk_protect_blocks: assert property (s_cmd_start and wp_d
        |=> stat_q[ST_WEPR] && err_q) // R15
        else $error("Protected area not refused");
    chk_reset_mode: assert property ($fell(reset) |-> !spm_q) // R19
        else $error("Mode bit not cleared by reset");
endmodule

// ==== bench/spfc_cpu_model.sv ====
`timescale 1ns/1ps
module spfc_cpu_model
    import spfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bench control
    input wire logic go,
    input wire logic irq,
    // Design side
    output logic halt_exec,
    input wire logic cpu_stall,
    input wire logic halt_release,
    input wire logic int_service_en,
    input wire logic ram_access_en,
    // Observed results
    output int stall_cyc,
    output int ram_off_cyc,
    output int irq_served,
    output logic released
);
    // =========================================================
    // HALT issue and stall bookkeeping
    logic irq_pend_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            halt_exec <= 1'b0;
            stall_cyc <= 0;
            ram_off_cyc <= 0;
            released <= 1'b0;
        end else begin
            halt_exec <= go;
            if (go) begin
                stall_cyc <= 0;
                ram_off_cyc <= 0;
                released <= 1'b0;
            end else begin
                if (cpu_stall) stall_cyc <= stall_cyc + 1;
                if (!ram_access_en) ram_off_cyc <= ram_off_cyc + 1;
                if (halt_release) released <= 1'b1;
            end
        end
    end

    // =========================================================
    // Request flag waits until servicing is allowed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_pend_q <= 1'b0;
            irq_served <= 0;
        end else if (irq) begin
            irq_pend_q <= 1'b1;
        end else if (irq_pend_q && int_service_en) begin
            irq_pend_q <= 1'b0;
            irq_served <= irq_served + 1;
        end
    end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
    import spfc_pkg::*;
;
    localparam int T_VB = 20;
    localparam int T_ER = 20;
    localparam int T_BL = 10;
    localparam int T_WR = 5;
    localparam int T_BYTE = 1080;

    typedef struct packed {
        logic [7:0] cmd, aph, apl, ach, acl, wd;
        logic [31:0] n;
        logic [7:0] st, la, lv;
    } spfc_row_s;

    logic clk, reset, psel, penable, pwrite, pready, pslverr, go, irq, released;
    logic [7:0] paddr, cpu_rd_addr, cpu_rd_data;
    logic [31:0] pwdata, prdata, last_rd;
    logic halt_exec, cpu_stall, halt_release, int_service_en, pin_hold, ram_access_en;
    logic last_err;
    int stall_cyc, ram_off_cyc, irq_served, fail_count, checks_done;

    spfc_row_s rows [9] = '{
        '{8'h05, 8'h00, 8'h10, 8'h00, 8'h00, 8'h3c, 32'(T_WR), 8'h00, 8'h10, 8'h3c},
        '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 32'(T_BL), 8'h02, 8'h10, 8'h3c},
        '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 32'(T_ER), 8'h00, 8'h10, 8'hff},
        '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 32'(T_BL), 8'h00, 8'h3f, 8'hff},
        '{8'h01, 8'h00, 8'h10, 8'h00, 8'h11, 8'h00, 32'(2 * T_BYTE), 8'h00, 8'h00, 8'hff},
        '{8'h01, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 32'(T_VB), 8'h00, 8'h00, 8'hff},
        '{8'h05, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 32'd1, 8'h02, 8'h10, 8'hff},
        '{8'h02, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 32'd1, 8'h02, 8'h10, 8'hff},
        '{8'h05, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 32'(T_WR), 8'h00, 8'h41, 8'h00}
    };

    spfc_ctrl #(.VERIFY_BLK_CYCLES(T_VB), .ERASE_CYCLES(T_ER), .BLANK_CYCLES(T_BL),
        .WRITE_CYCLES(T_WR)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_exec(halt_exec), .cpu_stall(cpu_stall),
        .halt_release(halt_release), .int_service_en(int_service_en), .pin_hold(pin_hold),
        .ram_access_en(ram_access_en), .cpu_rd_addr(cpu_rd_addr), .cpu_rd_data(cpu_rd_data));

    spfc_cpu_model cpu (.clk(clk), .reset(reset), .go(go), .irq(irq), .halt_exec(halt_exec),
        .cpu_stall(cpu_stall), .halt_release(halt_release), .int_service_en(int_service_en),
        .ram_access_en(ram_access_en), .stall_cyc(stall_cyc), .ram_off_cyc(ram_off_cyc),
        .irq_served(irq_served), .released(released));

    always #12.5 clk = ~clk;

    // =========================================================
    // Tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        last_rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        cmp("register read", exp, last_rd);
    endtask

    task automatic set_mode(input logic [7:0] v);
        wr(OFS_PCMD, PCMD_KEY);
        wr(OFS_MODE, v);
        wr(OFS_MODE, ~v);
        wr(OFS_MODE, v);
    endtask

    task automatic ld(input logic [7:0] a, input logic [7:0] exp);
        cpu_rd_addr <= a;
        repeat (2) @(posedge clk);
        cmp("flash load", {24'h000000, exp}, {24'h000000, cpu_rd_data});
    endtask

    task automatic halt_op();
        int n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (released !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            fail_count++;
            final_report();
        end
    endtask

    // =========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, go, irq} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        cpu_rd_addr = 8'h00;
        fail_count = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("pin_hold", 32'h0, {31'h0, pin_hold});
        rdc(OFS_MODE, 32'h7c);
        rdc(OFS_STAT, 32'h0);
        wr(OFS_MODE, 8'h01);
        rdc(OFS_STAT, 32'h01);
        rdc(OFS_MODE, 32'h7c);
        wr(OFS_STAT, 8'h00);
        wr(OFS_PCMD, PCMD_KEY);
        wr(OFS_MODE, 8'h01);
        wr(OFS_MODE, 8'h01);
        rdc(OFS_STAT, 32'h01);
        rdc(OFS_MODE, 32'h7c);
        wr(OFS_STAT, 8'h00);
        rdc(8'h24, 32'h0);
        cmp("pslverr", 32'h1, {31'h0, last_err});
        wr(OFS_CMD, 8'h05);
        rdc(OFS_CMD, 32'h05);
        set_mode(8'h01);
        rdc(OFS_MODE, 32'h7d);
        rdc(OFS_STAT, 32'h0);
        cmp("pin_hold", 32'h1, {31'h0, pin_hold});
        cmp("int_service_en", 32'h0, {31'h0, int_service_en});
        // Second reset in mid run drops the mode
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(OFS_MODE, 32'h7c);
        cmp("pin_hold", 32'h0, {31'h0, pin_hold});
        set_mode(8'h01);
        repeat (640) @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        foreach (rows[i]) begin
            wr(OFS_APH, rows[i].aph);
            wr(OFS_APL, rows[i].apl);
            wr(OFS_ACH, rows[i].ach);
            wr(OFS_ACL, rows[i].acl);
            wr(OFS_WBUF, rows[i].wd);
            wr(OFS_CMD, rows[i].cmd);
            wr(OFS_STAT, 8'h00);
            halt_op();
            cmp("stall cycles", rows[i].n, stall_cyc);
            cmp("ram off cycles", rows[i].n, ram_off_cyc);
            rdc(OFS_STAT, {24'h000000, rows[i].st});
            ld(rows[i].la, rows[i].lv);
        end
        cmp("irq served", 32'h0, irq_served);
        set_mode(8'h00);
        rdc(OFS_MODE, 32'h7c);
        repeat (3) @(posedge clk);
        cmp("irq served", 32'h1, irq_served);
        cmp("int_service_en", 32'h1, {31'h0, int_service_en});
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        cmp("stall cycles", 32'h0, stall_cyc);
        cmp("released", 32'h0, {31'h0, released});
        final_report();
    end
endmodule
